// File: core/cmfr_multi_frame_rx.sv
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module cmfr_multi_frame_rx
    import cmfr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire cmfr_rx_sym_s rx_sym,
    output logic rx_enable,
    output logic rx_irq_flag,
    output logic await_send
);
    cmfr_state_e state_r;
    logic [31:0] buf_rd;
    logic multi_frame_receive_mode;
    logic [4:0] mode_r;
    logic cfg_fault_r;
    logic rx_irq_r;
    logic [3:0] frame_cnt_r;
    logic [3:0] frames_done_r;
    logic [5:0] cnt_r;
    logic [7:0] len_r;
    logic [3:0] gap_r;
    logic rx_en_r;
    logic [11:0] aw_addr_r;
    logic aw_ok_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_ok_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_fire;
    logic rd_fire;
    logic start_cmd;
    logic idle_cmd;
    logic irq_clr;
    logic cfg_ok;
    logic byte_in;
    logic frame_done;
    logic len_over_now;
    logic store_byte;
    logic [2:0] slot;
    logic [5:0] byte_word;
    logic [5:0] status_word;
    logic last_frame;
    logic [1:0] proto;
    logic [1:0] rate;
    cmfr_slot_status_s status;

    assign proto = mode_r[MODE_PROTO_LSB +: 2];
    assign rate = mode_r[MODE_RATE_LSB +: 2];
    // Vicinity accepts only the 26k rate code, or the 53k code with the fast-inventory bit set
    assign cfg_ok = (proto != PROTO_VICINITY)
        || (rate == VIC_RATE_26K)
        || (rate == VIC_RATE_53K && mode_r[MODE_FAST_INV_BIT]);

    // Bus handshakes
    assign s_axi_awready = !aw_ok_r && !bvalid_r;
    assign s_axi_wready = !w_ok_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign wr_fire = aw_ok_r && w_ok_r && !bvalid_r;
    assign rd_fire = s_axi_arvalid && !rvalid_r;

    assign start_cmd = wr_fire && aw_addr_r == REG_CTRL && w_strb_r[0]
        && w_data_r[CTRL_START_BIT];
    assign idle_cmd = wr_fire && aw_addr_r == REG_CTRL && w_strb_r[0]
        && w_data_r[CTRL_IDLE_BIT];
    assign irq_clr = wr_fire && aw_addr_r == REG_IRQ_STATUS && w_strb_r[0]
        && w_data_r[IRQ_RX_BIT];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_ok_r <= 1'b0;
            aw_addr_r <= '0;
            w_ok_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ok_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ok_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_ok_r <= 1'b0;
                w_ok_r <= 1'b0;
                bvalid_r <= 1'b1;
                // Buffer is read-only to software
                bresp_r <= (aw_addr_r == REG_CTRL || aw_addr_r == REG_MODE
                    || aw_addr_r == REG_IRQ_STATUS) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            multi_frame_receive_mode <= 1'b0;
            mode_r <= '0;
        end
        else if (ce && wr_fire && w_strb_r[0])
        begin
            if (aw_addr_r == REG_CTRL)
                multi_frame_receive_mode <= w_data_r[CTRL_MULTI_BIT];
            if (aw_addr_r == REG_MODE)
                mode_r <= w_data_r[4:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (rd_fire)
            begin
                rvalid_r <= 1'b1;
                rresp_r <= RESP_OKAY;
                rdata_r <= '0;
                if (s_axi_araddr >= BUF_BASE && s_axi_araddr <= BUF_LAST)
                    rdata_r <= buf_rd;
                else
                case (s_axi_araddr)
                    REG_CTRL:
                        rdata_r[CTRL_MULTI_BIT] <= multi_frame_receive_mode;
                    REG_MODE:
                        rdata_r[4:0] <= mode_r;
                    REG_RX_STATUS:
                    begin
                        rdata_r[RXS_FRAMES_LSB +: 4] <= frames_done_r;
                        rdata_r[RXS_STATE_LSB +: 2] <= state_r;
                        rdata_r[RXS_CFG_FAULT_BIT] <= cfg_fault_r;
                    end
                    REG_IRQ_STATUS:
                        rdata_r[IRQ_RX_BIT] <= rx_irq_r;
                    default:
                        rresp_r <= RESP_SLVERR;
                endcase
            end
            else if (rvalid_r && s_axi_rready)
                rvalid_r <= 1'b0;
        end
    end

    // Frame assembly
    assign byte_in = state_r == st_recv && rx_sym.valid;
    assign frame_done = state_r == st_recv && rx_sym.frame_end;
    assign len_over_now = (cnt_r == '0) ? rx_sym.data > LEN_LIMIT
        : len_r > LEN_LIMIT;
    assign store_byte = byte_in && cnt_r < PAYLOAD_LIMIT
        && !len_over_now;
    assign slot = frame_cnt_r[2:0];
    assign byte_word = {slot, cnt_r[4:2]};
    assign status_word = {slot, STATUS_WORD_IDX};
    assign last_frame = !multi_frame_receive_mode
        || frame_cnt_r == FRAMES_MAX - 4'h1;

    cmfr_status_pack u_status (
        .byte_count(cnt_r),
        .len_byte(len_r),
        .crc_err(rx_sym.crc_err),
        .proto_err(rx_sym.proto_err),
        .collision(rx_sym.collision),
        .status(status)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= '0;
            len_r <= '0;
        end
        else if (ce)
        begin
            if (frame_done || start_cmd || state_r != st_recv)
            begin
                cnt_r <= '0;
                len_r <= '0;
            end
            else if (byte_in)
            begin
                if (cnt_r == '0)
                    len_r <= rx_sym.data;
                if (cnt_r != CNT_SAT)
                    cnt_r <= cnt_r + 6'h1;
            end
        end
    end

    // Memory without reset; unused bytes stay stale
    // One byte array per lane, so each has a single writer
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            logic [7:0] lane_mem [BUF_WORDS];
            always_ff @(posedge clk)
            begin
                if (ce && store_byte && cnt_r[1:0] == 2'(lane))
                    lane_mem[byte_word] <= rx_sym.data;
                else if (ce && frame_done)
                    lane_mem[status_word] <= status[lane*8 +: 8];
            end
            assign buf_rd[lane*8 +: 8] = lane_mem[s_axi_araddr[7:2]];
        end
    endgenerate

    // Sequencer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= st_idle;
            rx_en_r <= 1'b0;
            gap_r <= '0;
            frame_cnt_r <= '0;
            frames_done_r <= '0;
            cfg_fault_r <= 1'b0;
        end
        else if (ce)
        begin
            if (idle_cmd)
            begin
                state_r <= st_idle;
                rx_en_r <= 1'b0;
                frames_done_r <= frame_cnt_r;
            end
            else if (start_cmd)
            begin
                cfg_fault_r <= !cfg_ok;
                frame_cnt_r <= '0;
                frames_done_r <= '0;
                if (cfg_ok)
                begin
                    state_r <= st_recv;
                    rx_en_r <= 1'b1;
                end
            end
            else
            case (state_r)
                st_recv:
                    if (frame_done)
                    begin
                        rx_en_r <= 1'b0;
                        frame_cnt_r <= frame_cnt_r + 4'h1;
                        if (last_frame)
                        begin
                            state_r <= await_send_state;
                            frames_done_r <= frame_cnt_r + 4'h1;
                        end
                        else
                        begin
                            state_r <= st_gap;
                            gap_r <= GAP_LOAD;
                        end
                    end
                st_gap:
                    if (gap_r == '0)
                    begin
                        state_r <= st_recv;
                        rx_en_r <= 1'b1;
                    end
                    else
                        gap_r <= gap_r - 4'h1;
                default:
                    rx_en_r <= 1'b0;
            endcase
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_irq_r <= 1'b0;
        else if (ce)
        begin
            if (frame_done)
                rx_irq_r <= 1'b1;
            else if (irq_clr)
                rx_irq_r <= 1'b0;
        end
    end

    assign rx_enable = rx_en_r;
    assign rx_irq_flag = rx_irq_r;
    assign await_send = state_r == await_send_state;

    sequence s_frame_end;
        ce && frame_done && !idle_cmd && !start_cmd;
    endsequence

    sequence s_reopen;
        !rx_en_r [*6] ##1 rx_en_r;
    endsequence

    AST_GAP_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        (s_frame_end and !last_frame) |=> s_reopen)
        else $error("receiver gap wrong length");

    AST_EIGHTH: assert property (@(posedge clk) disable iff (!rst_n)
        (s_frame_end and frame_cnt_r == 4'h7)
            |=> state_r == await_send_state)
        else $error("no send wait after eighth frame");

    AST_IDLE_STOP: assert property (@(posedge clk) disable iff (!rst_n)
        ce && idle_cmd |=> !rx_en_r && state_r == st_idle)
        else $error("idle command did not stop reception");

    AST_CNT_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        ce && start_cmd && !idle_cmd |=> frame_cnt_r == '0
            && frames_done_r == '0)
        else $error("frame count not cleared on start");

    AST_IRQ_SET: assert property (@(posedge clk) disable iff (!rst_n)
        s_frame_end |=> rx_irq_r)
        else $error("receive flag not set after frame");

    AST_NO_LONG: assert property (@(posedge clk) disable iff (!rst_n)
        store_byte |-> !len_over_now && cnt_r < PAYLOAD_LIMIT)
        else $error("payload stored past limit");

    AST_MULTI_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
        state_r == st_gap |-> multi_frame_receive_mode
            || $past(multi_frame_receive_mode))
        else $error("restart outside multi mode");

    AST_FRAMES_MAX: assert property (@(posedge clk) disable iff (!rst_n)
        frame_cnt_r <= FRAMES_MAX && (state_r == st_recv
            -> frame_cnt_r < FRAMES_MAX))
        else $error("frame count beyond eight");

    AST_PUBLISH: assert property (@(posedge clk) disable iff (!rst_n)
        (s_frame_end and last_frame) |=> frames_done_r == $past(frame_cnt_r)
            + 4'h1)
        else $error("frame count not published");

    AST_FLAGS: assert property (@(posedge clk) disable iff (!rst_n)
        status.combined_rx_error_flag == (status.integrity_error_flag
            | status.short_frame_flag | status.collision_flag)
            && status.rsvd_hi == '0 && status.rsvd_lo == '0)
        else $error("status word flags inconsistent");

endmodule : cmfr_multi_frame_rx
`default_nettype wire

// File: core/cmfr_status_pack.sv
`timescale 1ns/10ps
`default_nettype none
module cmfr_status_pack
    import cmfr_pkg::*;
(
    input wire logic [5:0] byte_count,
    input wire logic [7:0] len_byte,
    input wire logic crc_err,
    input wire logic proto_err,
    input wire logic collision,
    output cmfr_slot_status_s status
);
    logic len_over;
    logic short_frame;

    assign len_over = len_byte > LEN_LIMIT;
    assign short_frame = {2'h0, byte_count} < len_byte;

    always_comb
    begin
        status = '0;
        status.byte_count = byte_count;
        status.integrity_error_flag = crc_err;
        status.short_frame_flag = proto_err | short_frame;
        status.collision_flag = collision;
        status.combined_rx_error_flag = crc_err | proto_err | short_frame
            | collision;
        status.length_fault_flag = len_over | short_frame;
    end
endmodule : cmfr_status_pack
`default_nettype wire

// File: shared/cmfr_pkg.sv
package cmfr_pkg;

    // Register byte offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_MODE = 12'h004;
    localparam logic [11:0] REG_RX_STATUS = 12'h008;
    localparam logic [11:0] REG_IRQ_STATUS = 12'h00C;
    localparam logic [11:0] BUF_BASE = 12'h100;
    localparam logic [11:0] BUF_LAST = 12'h1FC;

    // Control register fields
    localparam int CTRL_MULTI_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_IDLE_BIT = 2;
    // Mode register fields
    localparam int MODE_PROTO_LSB = 0;
    localparam int MODE_RATE_LSB = 2;
    localparam int MODE_FAST_INV_BIT = 4;
    localparam logic [1:0] PROTO_TYPE_B = 2'h1;
    localparam logic [1:0] PROTO_VICINITY = 2'h2;
    localparam logic [1:0] VIC_RATE_26K = 2'h2;
    localparam logic [1:0] VIC_RATE_53K = 2'h3;
    // Status register fields
    localparam int RXS_FRAMES_LSB = 0;
    localparam int RXS_STATE_LSB = 4;
    localparam int RXS_CFG_FAULT_BIT = 8;
    localparam int IRQ_RX_BIT = 0;

    // Buffer geometry
    localparam int SLOT_BYTES = 32;
    localparam int MAX_FRAMES = 8;
    localparam int MAX_PAYLOAD = 28;
    localparam int BUF_WORDS = SLOT_BYTES * MAX_FRAMES / 4;
    localparam logic [2:0] STATUS_WORD_IDX = 3'h7;
    localparam logic [5:0] PAYLOAD_LIMIT = 6'h1C;
    localparam logic [7:0] LEN_LIMIT = 8'h1C;
    localparam logic [5:0] CNT_SAT = 6'h3F;
    localparam logic [3:0] FRAMES_MAX = 4'h8;

    // Receiver off time between frames
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CARRIER_PERIOD_PS = 73746;
    localparam int GAP_MIN_CARRIER = 2;
    localparam int GAP_MAX_NS = 2000;
    localparam int GAP_MIN_CYC = (GAP_MIN_CARRIER * CARRIER_PERIOD_PS
        + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int GAP_MAX_CYC = GAP_MAX_NS * 1000 / CLK_PERIOD_PS;
    localparam logic [3:0] GAP_LOAD = 4'(GAP_MIN_CYC - 1);

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Symbol stream from the demodulator
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic frame_end;
        logic crc_err;
        logic proto_err;
        logic collision;
    } cmfr_rx_sym_s;

    // Slot status word, bytes 28..31 of a slot
    typedef struct packed {
        logic [18:0] rsvd_hi;
        logic length_fault_flag;
        logic combined_rx_error_flag;
        logic collision_flag;
        logic short_frame_flag;
        logic integrity_error_flag;
        logic [1:0] rsvd_lo;
        logic [5:0] byte_count;
    } cmfr_slot_status_s;

    typedef enum logic [1:0] {
        st_idle,
        st_recv,
        st_gap,
        await_send_state
    } cmfr_state_e;

endpackage : cmfr_pkg

// File: testbench/cmfr_card_model.sv
`timescale 1ns/10ps
`default_nettype none
module cmfr_card_model
    import cmfr_pkg::*;
(
    input wire logic clk,
    input wire logic rx_enable,
    output cmfr_rx_sym_s rx_sym
);
    initial rx_sym = '0;
    // One response: length byte first, then end marker with flags
    task send(input logic [7:0] len, input int n, input logic crc,
        input logic pe, input logic co);
        int k;
        @(posedge clk);
        while (rx_enable !== 1'b1)
        begin
            @(posedge clk);
        end
        for (k = 0; k < n; k++)
        begin
            rx_sym <= '{1'b1, (k == 0) ? len : len + 8'(k),
                1'b0, 1'b0, 1'b0, 1'b0};
            @(posedge clk);
        end
        rx_sym <= '{1'b0, ~rx_sym.data, 1'b1, crc, pe, co};
        @(posedge clk);
        rx_sym <= '{1'b0, ~rx_sym.data, 1'b0, 1'b0, 1'b0, 1'b0};
    endtask : send
endmodule : cmfr_card_model
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    fail_count++; $display("Error t=%0t got %h exp %h", $time, a, b); \
    end end
module tb
    import cmfr_pkg::*;
;
    logic clk, rst_n, awv, wv, bry, arv, rry;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdat, v;
    logic awr, wrd, bv, arr, rv, rx_en, irq, aw_snd;
    logic [1:0] bre, rre, r;
    logic [31:0] rdx;
    cmfr_rx_sym_s sym;
    int fail_count = 0, samples_checked = 0, cyc = 0, lo = 0, gap = 0;
    cmfr_multi_frame_rx u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_bresp(bre), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .s_axi_rdata(rdx), .s_axi_rresp(rre), .rx_sym(sym),
        .rx_enable(rx_en), .rx_irq_flag(irq), .await_send(aw_snd));
    cmfr_card_model u_card (.clk(clk), .rx_enable(rx_en), .rx_sym(sym));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (rx_en === 1'b0)
            lo <= lo + 1;
        else
        begin
            if (lo != 0)
                gap <= lo;
            lo <= 0;
        end
        if (cyc == 20000)
        begin
            fail_count++;
            end_sim();
        end
    end
    task end_sim();
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic sa, sw, sb;
        @(posedge clk);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        bry <= 1'b1;
        while (1)
        begin
            @(negedge clk);
            sa = awv && awr;
            sw = wv && wrd;
            sb = bv && bry;
            r = bre;
            @(posedge clk);
            if (sa)
                awv <= 1'b0;
            if (sw)
                wv <= 1'b0;
            if (sb)
            begin
                bry <= 1'b0;
                break;
            end
        end
    endtask : wr
    task rd(input logic [11:0] a);
        logic sa, sb;
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        while (1)
        begin
            @(negedge clk);
            sa = arv && arr;
            sb = rv && rry;
            v = rdx;
            r = rre;
            @(posedge clk);
            if (sa)
                arv <= 1'b0;
            if (sb)
            begin
                rry <= 1'b0;
                break;
            end
        end
    endtask : rd
    function automatic logic [31:0] st(int n, int len, logic c,
        logic p, logic o);
        logic s, f;
        s = p | (n < len);
        f = (len > 28) | (n < len);
        return {19'h0, f, c | s | o, o, s, c, 2'h0, 6'(n)};
    endfunction : st
    task t_map();
        rd(12'h010);
        `CHK(r, RESP_SLVERR)
        `CHK(v, 32'h0)
        wr(BUF_BASE, 32'h0);
        `CHK(r, RESP_SLVERR)
        `CHK(rx_en, 1'b0)
    endtask : t_map
    task t_multi();
        int f, ln[5], nb[5];
        logic ce_[5], co_[5];
        ln = '{5, 6, 30, 10, 4};
        nb = '{5, 6, 30, 4, 4};
        ce_ = '{0, 1, 0, 0, 0};
        co_ = '{0, 0, 0, 0, 1};
        wr(REG_MODE, 32'h1);
        wr(REG_CTRL, 32'h3);
        for (f = 0; f < 5; f++)
        begin
            u_card.send(8'(ln[f]), nb[f], ce_[f], 1'b0, co_[f]);
            @(negedge clk);
            `CHK(irq, 1'b1)
            if (f > 0)
                `CHK(gap >= GAP_MIN_CYC && gap <= GAP_MAX_CYC, 1'b1)
            wr(REG_IRQ_STATUS, 32'h1);
            @(negedge clk);
            `CHK(irq, 1'b0)
        end
        wr(REG_CTRL, 32'h5);
        @(negedge clk);
        `CHK(rx_en, 1'b0)
        rd(REG_RX_STATUS);
        `CHK(v[5:0], 6'h05)
        for (f = 0; f < 5; f++)
        begin
            rd(BUF_BASE + 12'(32 * f + 28));
            `CHK(v, st(nb[f], ln[f], ce_[f], 1'b0, co_[f]))
        end
        for (f = 0; f < 2; f++)
        begin
            rd(BUF_BASE + 12'(32 * f));
            v = {8'(ln[f] + 3), 8'(ln[f] + 2), 8'(ln[f] + 1), 8'(ln[f])};
            `CHK(rdx, v)
        end
    endtask : t_multi
    task t_single();
        wr(REG_CTRL, 32'h2);
        u_card.send(8'h03, 3, 1'b0, 1'b0, 1'b0);
        repeat (10) @(negedge clk);
        `CHK(rx_en, 1'b0)
        `CHK(aw_snd, 1'b1)
        wr(REG_CTRL, 32'h4);
    endtask : t_single
    task t_eight();
        int f;
        wr(REG_IRQ_STATUS, 32'h1);
        wr(REG_CTRL, 32'h3);
        rd(REG_RX_STATUS);
        `CHK(v[3:0], 4'h0)
        for (f = 0; f < 8; f++)
            u_card.send(8'h03, 3, 1'b0, 1'b0, 1'b0);
        repeat (10) @(negedge clk);
        `CHK(aw_snd, 1'b1)
        `CHK(irq, 1'b1)
        `CHK(rx_en, 1'b0)
        rd(REG_RX_STATUS);
        `CHK(v[5:0], 6'h38)
        rd(BUF_BASE + 12'(32 * 7 + 28));
        `CHK(v, st(3, 3, 1'b0, 1'b0, 1'b0))
        wr(REG_CTRL, 32'h4);
    endtask : t_eight
    task t_vic();
        wr(REG_MODE, 32'h0E);
        wr(REG_CTRL, 32'h3);
        rd(REG_RX_STATUS);
        `CHK(v[RXS_CFG_FAULT_BIT], 1'b1)
        `CHK(rx_en, 1'b0)
        wr(REG_MODE, 32'h1E);
        wr(REG_CTRL, 32'h3);
        repeat (3) @(negedge clk);
        `CHK(rx_en, 1'b1)
        wr(REG_CTRL, 32'h4);
    endtask : t_vic
    initial
    begin
        rst_n = 1'b0;
        {awv, wv, bry, arv, rry} = '0;
        awa = '0;
        ara = '0;
        wd = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_map();
        t_multi();
        t_single();
        t_eight();
        t_vic();
        end_sim();
    end
endmodule : tb
`default_nettype wire
